// *** ccpw_defs.vh ***
// Register map, field positions and reset values of the PWM generator
`ifndef CCPW_DEFS_VH
`define CCPW_DEFS_VH

// APB byte addresses
`define CCPW_OFS_TA_CNT   8'h00
`define CCPW_OFS_TA_PER   8'h04
`define CCPW_OFS_TA_CTL   8'h08
`define CCPW_OFS_TB_CNT   8'h0C
`define CCPW_OFS_TB_PER   8'h10
`define CCPW_OFS_TB_CTL   8'h14
`define CCPW_OFS_U4_LO    8'h18
`define CCPW_OFS_U4_SH    8'h1C
`define CCPW_OFS_U5_LO    8'h20
`define CCPW_OFS_U5_SH    8'h24
`define CCPW_OFS_U4_CTL   8'h28
`define CCPW_OFS_U5_CTL   8'h2C
`define CCPW_OFS_BANK     8'h30
`define CCPW_OFS_PIN      8'h34
`define CCPW_OFS_STAT     8'h38
// The drain config overlays the time base A count address
`define CCPW_OFS_ODC      8'h00

// Field positions
`define CCPW_TCTL_RUN     2
`define CCPW_BANK_SEL     4
`define CCPW_ODC_U4       3
`define CCPW_PIN_SEL_LSB  4

// Prescale codes
`define CCPW_PRE_1        2'b00
`define CCPW_PRE_4        2'b01

// Tick lengths in oscillator cycles, minus one
`define CCPW_LIM_1        6'h03
`define CCPW_LIM_4        6'h0F
`define CCPW_LIM_16       6'h3F

// Reset values and the PWM mode code
`define CCPW_RST_PER      8'hFF
`define CCPW_RST_PIN      8'h03
`define CCPW_PWM_MODE     2'b11

`endif

// *** ccpw_timebase.v ***
// One 8-bit time base with prescaler, period match and postscaler
`timescale 1ns/1ps
`default_nettype none
`include "ccpw_defs.vh"

module ccpw_timebase (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    input  wire [1:0] presc,
    input  wire [3:0] postsc,
    input  wire [7:0] period,
    input  wire       cnt_wr,
    input  wire [7:0] cnt_wdata,
    output reg  [7:0] count_q,
    output reg  [1:0] quarter,
    output reg        step,
    output wire       rollover,
    output wire       event_pulse
);

    reg  [5:0] fine_q;
    reg  [3:0] post_q;
    reg  [5:0] limit;
    wire       tick_end;

    ////////////////////////////////////////////////////////////////////
    // Fine count: one instruction cycle is four oscillator cycles
    // Step marks the last cycle of a quarter, so a registered clear lands on time
    always @* begin
        case (presc)
            `CCPW_PRE_1: begin
                limit   = `CCPW_LIM_1;
                quarter = fine_q[1:0];
                step    = 1'b1;
            end
            `CCPW_PRE_4: begin
                limit   = `CCPW_LIM_4;
                quarter = fine_q[3:2];
                step    = (fine_q[1:0] == 2'b11);
            end
            default: begin
                limit   = `CCPW_LIM_16;
                quarter = fine_q[5:4];
                step    = (fine_q[3:0] == 4'hF);
            end
        endcase
    end

    assign tick_end    = run & (fine_q == limit);
    assign rollover    = tick_end & (count_q == period);
    // Postscaler only thins out events; period is untouched
    assign event_pulse = rollover & (post_q == postsc);

    ////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_q  <= 6'h00;
            count_q <= 8'h00;
            post_q  <= 4'h0;
        end else begin
            if (cnt_wr) begin
                fine_q  <= 6'h00;
                count_q <= cnt_wdata;
            end else if (run) begin
                fine_q <= tick_end ? 6'h00 : fine_q + 6'h01;
                if (tick_end) begin
                    count_q <= rollover ? 8'h00 : count_q + 8'h01;
                end
            end
            if (rollover) begin
                post_q <= event_pulse ? 4'h0 : post_q + 4'h1;
            end
        end
    end

endmodule

`default_nettype wire

// *** ccpw_top.v ***
// PWM generator: APB registers, two time bases and two PWM units
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccpw_defs.vh"

module ccpw_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire [1:0]  pulse_output_pin_i,
    output reg  [1:0]  pulse_output_pin_o,
    output reg  [1:0]  pulse_output_pin_oe
);

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    wire        setup_ph;
    wire        wr_en;
    reg  [31:0] rd_d;
    reg         err_d;

    assign pready   = 1'b1;
    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite;

    ////////////////////////////////////////////////////////////////////
    // Shared registers

    reg        bank_q;
    reg  [7:0] odc_q;
    reg  [7:0] pin_q;
    reg  [1:0] flag_q;
    reg  [1:0] pin_s1_q;
    reg  [1:0] pin_s2_q;

    wire [15:0] tcnt;
    wire [15:0] tper;
    wire [13:0] tctl;
    wire [3:0]  tquar;
    wire [1:0]  tstep;
    wire [1:0]  troll;
    wire [1:0]  tevt;
    wire [15:0] ulo;
    wire [15:0] ush;
    wire [11:0] uctl;
    wire [1:0]  uout;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_q <= 1'b0;
            odc_q  <= 8'h00;
            pin_q  <= `CCPW_RST_PIN;
        end else if (wr_en) begin
            if (paddr == `CCPW_OFS_BANK) begin
                bank_q <= pwdata[`CCPW_BANK_SEL];
            end
            if (paddr == `CCPW_OFS_ODC && bank_q) begin
                odc_q <= {3'b000, pwdata[4:3], 3'b000};
            end
            if (paddr == `CCPW_OFS_PIN) begin
                pin_q <= {2'b00, pwdata[5:4], 2'b00, pwdata[1:0]};
            end
        end
    end

    // Postscaled timer events are sticky; a new event beats a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 2'b00;
        end else begin
            if (wr_en && paddr == `CCPW_OFS_STAT) begin
                flag_q <= (flag_q & ~pwdata[1:0]) | tevt;
            end else begin
                flag_q <= flag_q | tevt;
            end
        end
    end

    // Pin levels come from outside, so they pass two flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 2'b00;
            pin_s2_q <= 2'b00;
        end else begin
            pin_s1_q <= pulse_output_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Time bases

    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : g_tb
            localparam [7:0] CNT_A = (t == 0) ? `CCPW_OFS_TA_CNT
                                              : `CCPW_OFS_TB_CNT;
            localparam [7:0] PER_A = (t == 0) ? `CCPW_OFS_TA_PER
                                              : `CCPW_OFS_TB_PER;
            localparam [7:0] CTL_A = (t == 0) ? `CCPW_OFS_TA_CTL
                                              : `CCPW_OFS_TB_CTL;

            reg  [7:0] per_q;
            reg  [6:0] ctl_q;
            wire       cnt_wr;

            // With the bank bit set the A count address is the drain config
            assign cnt_wr = wr_en && paddr == CNT_A
                            && !(t == 0 && bank_q);

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    per_q <= `CCPW_RST_PER;
                    ctl_q <= 7'h00;
                end else if (wr_en) begin
                    if (paddr == PER_A) begin
                        per_q <= pwdata[7:0];
                    end
                    if (paddr == CTL_A) begin
                        ctl_q <= pwdata[6:0];
                    end
                end
            end

            ccpw_timebase u_tb (
                .pclk        (pclk),
                .presetn     (presetn),
                .run         (ctl_q[`CCPW_TCTL_RUN]),
                .presc       (ctl_q[1:0]),
                .postsc      (ctl_q[6:3]),
                .period      (per_q),
                .cnt_wr      (cnt_wr),
                .cnt_wdata   (pwdata[7:0]),
                .count_q     (tcnt[8*t+7:8*t]),
                .quarter     (tquar[2*t+1:2*t]),
                .step        (tstep[t]),
                .rollover    (troll[t]),
                .event_pulse (tevt[t])
            );

            assign tper[8*t+7:8*t] = per_q;
            assign tctl[7*t+6:7*t] = ctl_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // PWM units

    genvar u;
    generate
        for (u = 0; u < 2; u = u + 1) begin : g_unit
            localparam [7:0] LO_A  = (u == 0) ? `CCPW_OFS_U4_LO
                                              : `CCPW_OFS_U5_LO;
            localparam [7:0] SH_A  = (u == 0) ? `CCPW_OFS_U4_SH
                                              : `CCPW_OFS_U5_SH;
            localparam [7:0] CTL_A = (u == 0) ? `CCPW_OFS_U4_CTL
                                              : `CCPW_OFS_U5_CTL;

            reg  [7:0] lo_q;
            reg  [7:0] sh_q;
            reg  [5:0] ctl_q;
            reg  [1:0] lat_q;
            reg        out_q;
            wire       sel_b;
            wire       roll;
            wire       stp;
            wire [9:0] ext;
            wire [9:0] ext_nx;
            wire [9:0] duty_new;
            wire       pwm_on;

            // Unit picks its time base from the pin setup register
            assign sel_b  = pin_q[`CCPW_PIN_SEL_LSB + u];
            assign roll   = sel_b ? troll[1] : troll[0];
            assign stp    = sel_b ? tstep[1] : tstep[0];
            assign ext    = sel_b ? {tcnt[15:8], tquar[3:2]}
                                  : {tcnt[7:0], tquar[1:0]};
            // One quarter ahead, since the clear itself costs a register stage
            assign ext_nx = ext + 10'h001;
            assign duty_new = {lo_q, ctl_q[5:4]};
            assign pwm_on = (ctl_q[3:2] == `CCPW_PWM_MODE);

            // Software side: in PWM mode writes land in the front buffer only
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lo_q  <= 8'h00;
                    ctl_q <= 6'h00;
                end else if (wr_en) begin
                    if (paddr == LO_A) begin
                        lo_q <= pwdata[7:0];
                    end
                    if (paddr == CTL_A) begin
                        ctl_q <= pwdata[5:0];
                    end
                end
            end

            // In PWM mode the back buffer moves only at rollover, so a period never tears
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sh_q  <= 8'h00;
                    lat_q <= 2'b00;
                end else if (pwm_on && roll) begin
                    sh_q  <= lo_q;
                    lat_q <= ctl_q[5:4];
                end else if (wr_en && paddr == SH_A && !pwm_on) begin
                    sh_q <= pwdata[7:0];
                end
            end

            // Rollover outranks a match landing on the same cycle
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_q <= 1'b0;
                end else if (ctl_q == 6'h00) begin
                    out_q <= 1'b0;
                end else if (!pwm_on) begin
                    out_q <= 1'b0;
                end else if (roll) begin
                    out_q <= (duty_new != 10'h000);
                end else if (stp && ext_nx == {sh_q, lat_q}) begin
                    out_q <= 1'b0;
                end
            end

            assign ulo[8*u+7:8*u]  = lo_q;
            assign ush[8*u+7:8*u]  = sh_q;
            assign uctl[6*u+5:6*u] = ctl_q;
            assign uout[u]         = out_q;
        end
    endgenerate

    // Open drain only pulls low; a clear direction bit enables
    // Both pins in one process, so each output has a single driver
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_output_pin_o  <= 2'b00;
            pulse_output_pin_oe <= 2'b00;
        end else begin
            pulse_output_pin_o  <= uout & ~odc_q[`CCPW_ODC_U4 +: 2];
            pulse_output_pin_oe <= ~pin_q[1:0] & ~(odc_q[`CCPW_ODC_U4 +: 2] & uout);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux, sampled in the setup phase

    always @* begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        case (paddr)
            `CCPW_OFS_TA_CNT: begin
                if (bank_q) begin
                    rd_d[7:0] = odc_q;
                end else begin
                    rd_d[7:0] = tcnt[7:0];
                end
            end
            `CCPW_OFS_TA_PER: rd_d[7:0] = tper[7:0];
            `CCPW_OFS_TA_CTL: rd_d[6:0] = tctl[6:0];
            `CCPW_OFS_TB_CNT: rd_d[7:0] = tcnt[15:8];
            `CCPW_OFS_TB_PER: rd_d[7:0] = tper[15:8];
            `CCPW_OFS_TB_CTL: rd_d[6:0] = tctl[13:7];
            `CCPW_OFS_U4_LO:  rd_d[7:0] = ulo[7:0];
            `CCPW_OFS_U4_SH:  rd_d[7:0] = ush[7:0];
            `CCPW_OFS_U5_LO:  rd_d[7:0] = ulo[15:8];
            `CCPW_OFS_U5_SH:  rd_d[7:0] = ush[15:8];
            `CCPW_OFS_U4_CTL: rd_d[5:0] = uctl[5:0];
            `CCPW_OFS_U5_CTL: rd_d[5:0] = uctl[11:6];
            `CCPW_OFS_BANK:   rd_d[`CCPW_BANK_SEL] = bank_q;
            `CCPW_OFS_PIN:    rd_d[7:0] = pin_q;
            `CCPW_OFS_STAT:   rd_d[5:0] = {uout, pin_s2_q, flag_q};
            default:          err_d = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= err_d;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** ccpw_asserts.sv ***
// Port-level assertions for the PWM generator
`timescale 1ns/1ps
`default_nettype none
module ccpw_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  pulse_output_pin_i,
    input wire logic [1:0]  pulse_output_pin_o,
    input wire logic [1:0]  pulse_output_pin_oe
);
    logic       wr;
    logic       bank_q;
    logic [1:0] m4_q, m5_q, dir_q, odc_q;
    logic [5:0] c_d, h1_q, h2_q, h3_q, s_all, s_none;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    assign wr = psel & penable & pwrite;
    // Four samples of history, so the registered pin path has settled
    assign c_d = {odc_q, dir_q, m5_q == 2'h3, m4_q == 2'h3};
    assign s_all = c_d & h1_q & h2_q & h3_q;
    assign s_none = ~(c_d | h1_q | h2_q | h3_q);
    ////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {m4_q, m5_q, odc_q, bank_q} <= 7'h00;
            dir_q <= 2'h3;
            {h1_q, h2_q, h3_q} <= {3{6'h0C}};
        end else begin
            if (wr && paddr == 8'h28) m4_q <= pwdata[3:2];
            if (wr && paddr == 8'h2C) m5_q <= pwdata[3:2];
            if (wr && paddr == 8'h34) dir_q <= pwdata[1:0];
            if (wr && paddr == 8'h30) bank_q <= pwdata[4];
            if (wr && paddr == 8'h00 && bank_q) odc_q <= pwdata[4:3];
            h1_q <= c_d;
            h2_q <= h1_q;
            h3_q <= h2_q;
        end
    end
    chk_ready_high: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    chk_unmapped_err: assert property (psel && !penable && paddr > 8'h38
        |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (psel && penable && paddr <= 8'h38 |-> !pslverr)
        else $error("error on a mapped register");
    chk_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    chk_off_low4: assert property (s_none[0] |-> !pulse_output_pin_o[0])
        else $error("unit 4 pin high outside pwm mode");
    chk_off_low5: assert property (s_none[1] |-> !pulse_output_pin_o[1])
        else $error("unit 5 pin high outside pwm mode");
    chk_dir_input: assert property (&s_all[3:2] |-> pulse_output_pin_oe == 2'h0)
        else $error("input pin driven");
    chk_od_low: assert property (s_all[4] |-> !pulse_output_pin_o[0])
        else $error("open drain pin driven high");
    chk_drive_out: assert property (s_none[2] && s_none[4] |-> pulse_output_pin_oe[0])
        else $error("output pin not driven");
    cover property (wr && paddr == 8'h28 && pwdata[3:2] == 2'h3);
    cover property (psel && penable && pslverr);
    cover property (s_all[4] && $rose(pulse_output_pin_oe[0]));
endmodule
bind ccpw_top ccpw_asserts i_ccpw_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_output_pin_i(pulse_output_pin_i),
    .pulse_output_pin_o(pulse_output_pin_o), .pulse_output_pin_oe(pulse_output_pin_oe));
`default_nettype wire

// *** ccpw_load.sv ***
// Pin load: pull-ups on both pulse pins and a timer on one of them
`timescale 1ns/1ps
`default_nettype none
module ccpw_load (
    input  wire logic       pclk,
    input  wire logic       sel,
    input  wire logic [1:0] drv_o,
    input  wire logic [1:0] drv_oe,
    output wire logic [1:0] level,
    output var  int         hi_cnt,
    output var  int         per_cnt
);
    int   cyc = 0;
    int   t_up = 0;
    // Starts at the pulled-up idle level, so reset shows no false edge
    logic last = 1'h1;
    ////////////////////////////////////////
    // A released pin is pulled high, which open drain relies on
    assign level = (drv_oe & drv_o) | ~drv_oe;
    // Sampled on the falling edge, away from the registered pin updates
    always @(negedge pclk) begin
        cyc = cyc + 1;
        if (level[sel] && !last) begin
            per_cnt = cyc - t_up;
            t_up = cyc;
        end
        if (!level[sel] && last) begin
            hi_cnt = cyc - t_up;
        end
        last = level[sel];
    end
endmodule
`default_nettype wire

// *** ccpw_top_bench.sv ***
// Self-checking bench for the PWM generator
`timescale 1ns/1ps
`default_nettype none
module ccpw_top_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, msel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0]  pin_o, pin_oe, pin_lvl;
    int          n_fail, tests_run, cyc, seed, hi_cnt, per_cnt, hs, p, d;
    ccpw_top i_ccpw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_output_pin_i(pin_lvl), .pulse_output_pin_o(pin_o),
        .pulse_output_pin_oe(pin_oe));
    ccpw_load i_ccpw_load (.pclk(pclk), .sel(msel), .drv_o(pin_o), .drv_oe(pin_oe),
        .level(pin_lvl), .hi_cnt(hi_cnt), .per_cnt(per_cnt));
    always #25 pclk = ~pclk;
    ////////////////////////////////////////
    // Nine runs of at most seven 640-cycle periods stay well below this
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("Compares %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            n_fail++;
            $display("[ERR] %0t count got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input int w, input int a, input int wd);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w[0];
        paddr <= a[7:0];
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task rd_chk(input int a, input int e);
        apb(0, a, 0);
        cmp_reg(rdat, e);
    endtask
    task sample(input int m);
        hs = 0;
        repeat (m) begin
            @(negedge pclk);
            // An unknown level yields an impossible count and so a mismatch
            hs += (pin_lvl[msel] === 1'b0) ? 0 : (pin_lvl[msel] === 1'b1) ? 1 : m + 1;
        end
        @(posedge pclk);
    endtask
    function logic [31:0] rst_val(input logic [7:0] a);
        case (a)
            8'h04, 8'h10: return 32'hFF;
            8'h34: return 32'h03;
            8'h38: return 32'h0C;
            default: return 32'h00;
        endcase
    endfunction
    task run_pwm(input int u, input int b, input int pc, input int p, input int d);
        int pre, n, nb;
        pre = (pc == 0) ? 1 : (pc == 1) ? 4 : 16;
        n = (p + 1) * 4 * pre;
        msel <= u[0];
        apb(1, 8'h28 + 4 * u, 0);
        repeat (2) @(posedge pclk);
        sample(16);
        cmp_cnt(hs, 0);
        apb(1, 8'h04 + 12 * b, p);
        apb(1, 8'h00 + 12 * b, 0);
        apb(1, 8'h18 + 8 * u, d >> 2);
        apb(1, 8'h28 + 4 * u, (d & 3) << 4);
        apb(1, 8'h34, b << (4 + u));
        apb(1, 8'h08 + 12 * b, ($random(seed) & 8'h78) | 4 | pc);
        apb(1, 8'h28 + 4 * u, ((d & 3) << 4) | 12 | ($random(seed) & 3));
        repeat (3 * n + 40) @(posedge pclk);
        if (d == 0 || d >= 4 * (p + 1)) begin
            sample(n);
            cmp_cnt(hs, d ? n : 0);
        end else begin
            cmp_cnt(per_cnt, n);
            cmp_cnt(hi_cnt, d * pre);
        end
        rd_chk(8'h1C + 8 * u, d >> 2);
        apb(1, 8'h1C + 8 * u, $random(seed));
        rd_chk(8'h1C + 8 * u, d >> 2);
        if (d > 0 && d < 4 * (p + 1)) begin
            nb = 1 + $unsigned($random(seed)) % p;
            apb(1, 8'h18 + 8 * u, nb);
            repeat (3 * n + 40) @(posedge pclk);
            cmp_cnt(hi_cnt, (nb * 4 + (d & 3)) * pre);
        end
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, msel} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        tests_run = 0;
        seed = 12;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (int a = 0; a <= 56; a += 4) rd_chk(a, rst_val(a[7:0]));
        rd_chk(8'h3C, 0);
        cmp_reg({31'h0, rerr}, 1);
        apb(1, 8'hFC, 8'h5A);
        cmp_reg({31'h0, rerr}, 1);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed) & 8'hFF;
            apb(1, 8'h18 + 8 * (i % 2), d);
            rd_chk(8'h18 + 8 * (i % 2), d);
        end
        apb(1, 8'h34, 0);
        for (int i = 0; i < 8; i++) begin
            p = 1 + $unsigned($random(seed)) % 9;
            d = 1 + $unsigned($random(seed)) % (4 * p + 3);
            if (i == 0) d = 0;
            if (i == 1) d = 4 * p + 4;
            if (i == 2) d = 4 * p + 3;
            run_pwm(i % 2, i / 2 % 2, i % 4, p, d);
        end
        apb(1, 8'h30, 8'h10);
        apb(1, 8'h00, 8'h08);
        rd_chk(8'h00, 8'h08);
        apb(1, 8'h30, 0);
        run_pwm(0, 0, 1, 5, 9);
        report_and_stop();
    end
endmodule
`default_nettype wire
